//--- src/dmx_defines.vh
// Constants for the data-move instruction executor
// Operation
// - Pointer load puts 12-bit literal in pointer
// - First cycle high 4 bits, second low byte
// - File copy goes to W or back
// - 8-bit address reaches whole 256-byte bank
// - Access bit 0 uses access bank
// - Access bit 1 uses bank select register
// - Two-word copy with 12-bit source, destination
// - Copy may use W; flags unchanged
// - Copy: read first cycle, write second end
// - Bank load writes literal to bank register
// - Store writes W to file register
`ifndef DMX_DEFINES_VH
`define DMX_DEFINES_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define DMX_ADDR_INSTR   8'h00
`define DMX_ADDR_STATUS  8'h04
`define DMX_ADDR_ACCUM   8'h08
`define DMX_ADDR_BANK    8'h0c
`define DMX_ADDR_PTR0    8'h10
`define DMX_ADDR_PTR1    8'h14
`define DMX_ADDR_PTR2    8'h18

// ----------------------------------------
// Status fields
// ----------------------------------------
`define DMX_ST_Z         2
`define DMX_ST_N         4
`define DMX_ST_BUSY      8
`define DMX_ST_SECOND    9
`define DMX_ST_ILLEGAL   10

// ----------------------------------------
// Encodings and data space
// ----------------------------------------
`define DMX_OP_COPYF     6'b010100
`define DMX_OP_STORE     7'b0110111
`define DMX_OP_BANKLIT   8'h01
`define DMX_OP_ACCLIT    8'h0e
`define DMX_OP_PTRLIT    10'b1110111000
`define DMX_OP_FF_SRC    4'hc
`define DMX_OP_SECOND    4'hf
`define DMX_ACC_SPLIT    8'h60
`define DMX_ACC_HI_BANK  4'hf
`define DMX_ACCUM_LOC    12'hfe8
`define DMX_PTR_COUNT    3

// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define DMX_Q1           2'd0
`define DMX_Q2           2'd1
`define DMX_Q3           2'd2
`define DMX_Q4           2'd3
`define DMX_MODE_NONE    2'd0
`define DMX_MODE_PTR     2'd1
`define DMX_MODE_FF      2'd2
`define DMX_RST_BYTE     8'h00
`define DMX_RST_PTR      12'h000
`define DMX_RESP_OKAY    2'b00
`define DMX_RESP_SLVERR  2'b10

`endif

//--- src/dmx_axil_slave.v
// AXI4-Lite slave front end for the data-move executor
`timescale 1ns/1ns
`include "dmx_defines.vh"

module dmx_axil_slave (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Write address and data
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // Write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // Read channels
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Core side
  output wire        wr_en,
  output wire [7:0]  wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0]  wr_strb,
  input  wire        wr_stall,
  input  wire        wr_err,
  input  wire [31:0] rd_data,
  input  wire        rd_err
);

  reg        aw_full_q;
  reg        w_full_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  assign awready = !aw_full_q && !bvalid;
  assign wready  = !w_full_q && !bvalid;
  assign arready = !rvalid;
  // Stall holds both beats so the master sees back-pressure
  assign wr_en   = aw_full_q && w_full_q && !bvalid && !wr_stall;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `DMX_RESP_OKAY;
      rvalid    <= 1'b0;
      rresp     <= `DMX_RESP_OKAY;
      rdata     <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_en) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_err ? `DMX_RESP_SLVERR : `DMX_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_data;
        rresp  <= rd_err ? `DMX_RESP_SLVERR : `DMX_RESP_OKAY;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- src/dmx_core.v
// Data-move instruction decode and execute core with register access
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "dmx_defines.vh"

module dmx_core (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Data space port
  output reg  [11:0] dmem_addr_q,
  output reg  [7:0]  dmem_wdata_q,
  output reg         dmem_we_q,
  input  wire [7:0]  dmem_rdata
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [1:0]  q_q;
  reg  [15:0] pend_word_q;
  reg         pend_q;
  reg  [15:0] ir_q;
  reg         act_q;
  reg  [1:0]  mode_q;
  reg  [1:0]  sel_q;
  reg  [7:0]  hold_q;
  reg  [7:0]  rd_q;
  reg  [7:0]  accum_q;
  reg  [7:0]  bank_q;
  wire [11:0] ptr_q [0:`DMX_PTR_COUNT-1];
  reg         flag_n_q;
  reg         flag_z_q;
  reg         illegal_q;

  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         wr_err;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  wire wr_instr  = (wr_addr == `DMX_ADDR_INSTR);
  wire wr_status = (wr_addr == `DMX_ADDR_STATUS);
  // A second word may not overwrite one not yet taken
  wire wr_stall  = wr_instr && pend_q;

  dmx_axil_slave u_slave (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awaddr   (s_axi_awaddr),
    .awvalid  (s_axi_awvalid),
    .awready  (s_axi_awready),
    .wdata    (s_axi_wdata),
    .wstrb    (s_axi_wstrb),
    .wvalid   (s_axi_wvalid),
    .wready   (s_axi_wready),
    .bresp    (s_axi_bresp),
    .bvalid   (s_axi_bvalid),
    .bready   (s_axi_bready),
    .araddr   (s_axi_araddr),
    .arvalid  (s_axi_arvalid),
    .arready  (s_axi_arready),
    .rdata    (s_axi_rdata),
    .rresp    (s_axi_rresp),
    .rvalid   (s_axi_rvalid),
    .rready   (s_axi_rready),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_strb  (wr_strb),
    .wr_stall (wr_stall),
    .wr_err   (wr_err),
    .rd_data  (rd_data),
    .rd_err   (rd_err)
  );

  // Only instruction and status take writes; the rest answer error
  always @* begin
    wr_err = !(wr_instr || wr_status);
  end

  // Read mux, captured when the read address is taken
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      `DMX_ADDR_INSTR:  rd_data = {16'h0000, pend_word_q};
      `DMX_ADDR_STATUS: begin
        rd_data[`DMX_ST_N]       = flag_n_q;
        rd_data[`DMX_ST_Z]       = flag_z_q;
        rd_data[`DMX_ST_BUSY]    = pend_q || act_q;
        rd_data[`DMX_ST_SECOND]  = (mode_q != `DMX_MODE_NONE);
        rd_data[`DMX_ST_ILLEGAL] = illegal_q;
      end
      `DMX_ADDR_ACCUM:  rd_data = {24'h00_0000, accum_q};
      `DMX_ADDR_BANK:   rd_data = {24'h00_0000, bank_q};
      `DMX_ADDR_PTR0:   rd_data = {20'h0_0000, ptr_q[0]};
      `DMX_ADDR_PTR1:   rd_data = {20'h0_0000, ptr_q[1]};
      `DMX_ADDR_PTR2:   rd_data = {20'h0_0000, ptr_q[2]};
      default:          rd_err  = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // First-word forms are masked while a second word is due
  wire       in_ptr   = (mode_q == `DMX_MODE_PTR);
  wire       in_ff    = (mode_q == `DMX_MODE_FF);
  wire       second   = (ir_q[15:12] == `DMX_OP_SECOND);
  wire       op_copyf = !in_ptr && !in_ff && (ir_q[15:10] == `DMX_OP_COPYF);
  wire       op_store = !in_ptr && !in_ff && (ir_q[15:9] == `DMX_OP_STORE);
  wire       op_bank  = !in_ptr && !in_ff && (ir_q[15:8] == `DMX_OP_BANKLIT);
  wire       op_acc   = !in_ptr && !in_ff && (ir_q[15:8] == `DMX_OP_ACCLIT);
  wire       op_ptr1  = !in_ptr && !in_ff && (ir_q[15:6] == `DMX_OP_PTRLIT);
  wire       op_ff1   = !in_ptr && !in_ff && (ir_q[15:12] == `DMX_OP_FF_SRC);
  wire       op_ptr2  = in_ptr && second;
  wire       op_ff2   = in_ff && second;
  wire       known    = op_copyf || op_store || op_bank || op_acc || op_ptr1
                        || op_ff1 || op_ptr2 || op_ff2;
  wire       bad_sel  = op_ptr1 && (ir_q[5:4] == 2'd3);
  wire       dest_f   = ir_q[9];
  reg  [11:0] ea;

  // Banked or access-bank address for single-word forms
  always @* begin
    if (op_ff1 || op_ff2) begin
      ea = ir_q[11:0];
    end else if (!ir_q[8]) begin
      if (ir_q[7:0] < `DMX_ACC_SPLIT) begin
        ea = {4'h0, ir_q[7:0]};
      end else begin
        ea = {`DMX_ACC_HI_BANK, ir_q[7:0]};
      end
    end else begin
      ea = {bank_q[3:0], ir_q[7:0]};
    end
  end

  // The accumulator is also a location of the data space
  wire       ea_is_acc = (dmem_addr_q == `DMX_ACCUM_LOC);
  wire [7:0] rval      = ea_is_acc ? accum_q : dmem_rdata;

  // ----------------------------------------
  // Pointer registers, one per entry
  // ----------------------------------------
  // Both halves land at the Q4 edge; select three has no entry
  wire       ptr_hi_we  = (q_q == `DMX_Q4) && act_q && op_ptr1 && !bad_sel;
  wire       ptr_lo_we  = (q_q == `DMX_Q4) && act_q && op_ptr2;
  wire [2:0] ptr_hi_hot = 3'h1 << ir_q[5:4];
  wire [2:0] ptr_lo_hot = 3'h1 << sel_q;
  genvar     g;

  generate
    for (g = 0; g < `DMX_PTR_COUNT; g = g + 1) begin : g_ptr
      reg [11:0] entry_q;

      always @(posedge aclk) begin
        if (!aresetn) begin
          entry_q <= `DMX_RST_PTR;
        end else if (ptr_hi_we && ptr_hi_hot[g]) begin
          entry_q[11:8] <= ir_q[3:0];
        end else if (ptr_lo_we && ptr_lo_hot[g]) begin
          entry_q[7:0] <= ir_q[7:0];
        end
      end

      assign ptr_q[g] = entry_q;
    end
  endgenerate

  // ----------------------------------------
  // Quarter-phase sequencer and execution
  // ----------------------------------------

  always @(posedge aclk) begin
    if (!aresetn) begin
      q_q          <= `DMX_Q1;
      pend_word_q  <= 16'h0000;
      pend_q       <= 1'b0;
      ir_q         <= 16'h0000;
      act_q        <= 1'b0;
      mode_q       <= `DMX_MODE_NONE;
      sel_q        <= 2'd0;
      hold_q       <= `DMX_RST_BYTE;
      rd_q         <= `DMX_RST_BYTE;
      accum_q      <= `DMX_RST_BYTE;
      bank_q       <= `DMX_RST_BYTE;
      flag_n_q     <= 1'b0;
      flag_z_q     <= 1'b0;
      illegal_q    <= 1'b0;
      dmem_addr_q  <= 12'h000;
      dmem_wdata_q <= `DMX_RST_BYTE;
      dmem_we_q    <= 1'b0;
    end else begin
      // Free-running divider: one instruction cycle is four clocks
      q_q       <= q_q + 2'd1;
      dmem_we_q <= 1'b0;
      if (wr_en && wr_instr && (wr_strb[1:0] == 2'b11)) begin
        pend_word_q <= wr_data[15:0];
        pend_q      <= 1'b1;
      end
      // Clear by writing one; a new fault in the same cycle wins
      if (wr_en && wr_status && wr_strb[1] && wr_data[`DMX_ST_ILLEGAL]) begin
        illegal_q <= 1'b0;
      end
      case (q_q)
        `DMX_Q1: begin
          // A word written late in a cycle waits for the next Q1
          if (pend_q) begin
            ir_q   <= pend_word_q;
            act_q  <= 1'b1;
            pend_q <= 1'b0;
          end
        end
        `DMX_Q2: begin
          if (act_q) begin
            dmem_addr_q <= ea;
          end
        end
        `DMX_Q3: begin
          if (act_q) begin
            rd_q <= rval;
            if (op_ff1) begin
              hold_q <= rval;
            end
            // Writes to the accumulator location never reach the data port
            if (op_copyf && dest_f && !ea_is_acc) begin
              dmem_we_q    <= 1'b1;
              dmem_wdata_q <= rval;
            end
            if (op_store && !ea_is_acc) begin
              dmem_we_q    <= 1'b1;
              dmem_wdata_q <= accum_q;
            end
            if (op_ff2 && !ea_is_acc) begin
              dmem_we_q    <= 1'b1;
              dmem_wdata_q <= hold_q;
            end
          end
        end
        default: begin
          if (act_q) begin
            act_q <= 1'b0;
            if (op_copyf) begin
              if (!dest_f) begin
                accum_q <= rd_q;
              end
              flag_n_q <= rd_q[7];
              flag_z_q <= (rd_q == 8'h00);
            end
            if (op_acc) begin
              accum_q <= ir_q[7:0];
            end
            if (op_bank) begin
              bank_q <= ir_q[7:0];
            end
            if (op_ff2 && ea_is_acc) begin
              accum_q <= hold_q;
            end
            if (op_ptr1 && !bad_sel) begin
              sel_q  <= ir_q[5:4];
              mode_q <= `DMX_MODE_PTR;
            end
            if (op_ff1) begin
              mode_q <= `DMX_MODE_FF;
            end
            if (in_ptr || in_ff) begin
              mode_q <= `DMX_MODE_NONE;
            end
            if (!known || bad_sel) begin
              illegal_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

endmodule

//--- dv/dmx_core_properties.sv
// Concurrent checks on the data-move core ports
`timescale 1ns/1ns
module dmx_core_properties (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Bus handshakes
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // Data space
  input logic [11:0] dmem_addr_q,
  input logic        dmem_we_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_we_gap;
    !dmem_we_q [*3];
  endsequence
  a_read_latency: assert property (s_ar_take |=> s_axi_rvalid) else $error("read answer missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  a_we_spacing: assert property (dmem_we_q |=> s_we_gap) else $error("write pulses too close");
  a_we_addr_held: assert property (dmem_we_q |-> $stable(dmem_addr_q)) else $error("address moved");
  a_accum_not_mem: assert property (dmem_we_q |-> dmem_addr_q != 12'hfe8) else $error("accum hit memory");
endmodule

bind dmx_core dmx_core_properties i_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .dmem_addr_q, .dmem_we_q);

//--- dv/tb.sv
// Self-checking bench for the data-move core
`timescale 1ns/1ns
`include "dmx_defines.vh"
module tb;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [7:0]  awa = 8'h00, ara = 8'h00;
  reg  [31:0] wd = 32'h0, rd;
  reg         awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  wire        awr, wr, bv, arr, rv, we;
  wire [1:0]  br, rr;
  wire [31:0] rdt;
  wire [11:0] da;
  wire [7:0]  dw;
  reg  [7:0]  mem [0:4095];
  reg  [7:0]  ref_mem [0:4095];
  wire [7:0]  drd = mem[da];
  reg  [1:0]  rs;
  reg  [11:0] src, dst;
  reg         ta, tw, td, tv;
  integer     failures = 0, cmp_count = 0, m_w = 0, m_bk = 0, m_n = 0, m_z = 0, m_sec = 0, m_ill = 0, i, j, k, f, v;
  integer     m_ptr [0:2];

  always #10 aclk = ~aclk;
  always @(posedge aclk) if (we) mem[da] <= dw;

  dmx_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .dmem_addr_q(da),
    .dmem_wdata_q(dw), .dmem_we_q(we), .dmem_rdata(drd));

  // ----------------------------------------
  // Bus tasks and reference model
  // ----------------------------------------
  task chk(input [31:0] e, input [31:0] g, input string n);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("unexpected %0s: expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Ready is sampled mid-cycle, where it already equals its value at the next edge
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= $urandom % 2;
      td = 1'b0;
      while (!td) begin
        @(negedge aclk);
        ta = awr;
        tw = wr;
        tv = bv;
        td = bv && brdy;
        rs = br;
        @(posedge aclk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
        // A late ready keeps the answer waiting for a cycle
        if (td) brdy <= 1'b0;
        else if (tv) brdy <= 1'b1;
      end
      chk(er, rs, "bresp");
    end
  endtask
  task axr(input [7:0] a);
    begin
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= $urandom % 2;
      td = 1'b0;
      while (!td) begin
        @(negedge aclk);
        ta = arr;
        tv = rv;
        td = rv && rrdy;
        rd = rdt;
        rs = rr;
        @(posedge aclk);
        if (ta) arv <= 1'b0;
        if (td) rrdy <= 1'b0;
        else if (tv) rrdy <= 1'b1;
      end
    end
  endtask
  task ex(input [15:0] w);
    begin
      axw(`DMX_ADDR_INSTR, {16'h0, w}, `DMX_RESP_OKAY);
      rd = 32'h100;
      while (rd[`DMX_ST_BUSY]) axr(`DMX_ADDR_STATUS);
    end
  endtask
  task state_cmp;
    begin
      axr(`DMX_ADDR_ACCUM);
      chk(m_w, rd, "accum");
      axr(`DMX_ADDR_BANK);
      chk(m_bk, rd, "bank");
      axr(`DMX_ADDR_STATUS);
      chk(m_n, rd[`DMX_ST_N], "neg");
      chk(m_z, rd[`DMX_ST_Z], "zero");
      chk(m_sec, rd[`DMX_ST_SECOND], "second");
      chk(m_ill, rd[`DMX_ST_ILLEGAL], "illegal");
      for (j = 0; j < 3; j = j + 1) begin
        axr(8'h10 + 4 * j);
        chk(m_ptr[j], rd, "pointer");
      end
    end
  endtask
  function [11:0] ea(input [7:0] fa, input a);
    ea = a ? {m_bk[3:0], fa} : (fa < 8'h60 ? {4'h0, fa} : {4'hf, fa});
  endfunction
  function [7:0] get(input [11:0] a);
    get = (a == 12'hfe8) ? m_w[7:0] : ref_mem[a];
  endfunction
  task put(input [11:0] a, input [7:0] d);
    if (a == 12'hfe8) m_w = d;
    else ref_mem[a] = d;
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    v = $urandom(32'h16d6);
    for (i = 0; i < 3; i = i + 1) m_ptr[i] = 0;
    for (i = 0; i < 4096; i = i + 1) begin
      v = $urandom;
      mem[i] = v;
      ref_mem[i] = v;
    end
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    state_cmp;
    axr(8'h1c);
    chk(`DMX_RESP_SLVERR, rs, "rresp");
    axw(`DMX_ADDR_ACCUM, 32'h5a, `DMX_RESP_SLVERR);
    for (i = 0; i < 8; i = i + 1) begin
      k = (i == 0) ? 0 : $urandom % 256;
      ex({8'h0e, k[7:0]});
      m_w = k;
      v = $urandom % 256;
      ex({8'h01, v[7:0]});
      m_bk = v;
      state_cmp;
      f = $urandom % 256;
      src = ea(f[7:0], i[0]);
      ex({7'b0110111, i[0], f[7:0]});
      put(src, m_w[7:0]);
      chk(ref_mem[src], mem[src], "stored");
      if (i > 1) f = $urandom % 256;
      src = ea(f[7:0], i[0]);
      ex({6'b010100, i[1], i[0], f[7:0]});
      v = get(src);
      if (i[1]) put(src, v[7:0]);
      else m_w = v;
      m_n = v[7];
      m_z = (v == 0);
      state_cmp;
      chk(ref_mem[src], mem[src], "copied");
      f = i % 3;
      v = $urandom % 4096;
      ex({8'hee, 2'b00, f[1:0], v[11:8]});
      m_ptr[f] = (v & 32'hf00) | (m_ptr[f] & 32'hff);
      m_sec = 1;
      state_cmp;
      ex({8'hf0, v[7:0]});
      m_ptr[f] = v;
      m_sec = 0;
      state_cmp;
      src = (i == 3) ? 12'hfe8 : $urandom;
      dst = (i == 4) ? 12'hfe8 : $urandom % 32'hf00;
      ex({4'hc, src});
      ex({4'hf, dst});
      put(dst, get(src));
      state_cmp;
      chk(ref_mem[dst], mem[dst], "moved");
    end
    // Pointer select three and a missing second word are refused
    ex(16'hee35);
    m_ill = 1;
    state_cmp;
    axr(`DMX_ADDR_INSTR);
    chk(32'hee35, rd, "instr");
    axw(`DMX_ADDR_STATUS, 32'h400, `DMX_RESP_OKAY);
    m_ill = 0;
    state_cmp;
    ex({4'hc, 12'h123});
    ex(16'h0e77);
    m_ill = 1;
    state_cmp;
    final_report;
  end

  // Roughly ten times the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    failures = failures + 1;
    final_report;
  end
endmodule
